// ---- hdl/dac2_output_config_regs.sv ----
`timescale 1ns/1ns
`include "dac2_cfg_defines.svh"

// How it works
// - bits 7-6 at 0x6C pick positive leg drive: line, headphone, 4 ohm, debug.
// - bits 5-3 at 0x6C pick positive leg level, codes 4-7 give -8..-26 dB.
// - bits 7-6 at 0x6D pick negative leg drive with the same encodings.
// - bits 5-3 at 0x6D pick negative leg level, codes 4-7 give -8..-26 dB.
// - reserved bits read zero; software writes zero into them.
// - bit 0 at 0x6C selects 24 kHz band (0) or 96 kHz band (1).
// - bit 1 at 0x6D selects 10 Vrms (0) or 5 Vrms (1) full scale.
// - bit 0 at 0x6D selects limited (0) or rail-to-rail (1) common mode.
// - register 0x6C resets to 0x20.
// - register 0x6D resets to 0x20.
// - register 0x6E holds the 8-bit channel 2A volume, reset 0xC9.
// - volume 0 mutes, 1 is -100 dB, 0.5 dB steps, 201 is 0 dB.
module dac2_output_config_regs
  import dac2_cfg_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  output logic regReadValid,
  output logic regAddrError,
  output logic reservedWriteSeen,
  output logic [1:0] pos_leg_drive_type,
  output logic [2:0] pos_leg_level_code,
  output logic [1:0] neg_leg_drive_type,
  output logic [2:0] neg_leg_level_code,
  output logic dac2_bandwidth_sel,
  output logic dac2_full_scale_sel,
  output logic dac2_common_mode_tolerance,
  output logic [7:0] dac2a_volume_code,
  output logic [3:0] posLegDriveOneHot,
  output logic [3:0] negLegDriveOneHot,
  output logic [4:0] posLegAttenDb,
  output logic [4:0] negLegAttenDb,
  output logic posLegLevelInvalid,
  output logic negLegLevelInvalid,
  output logic volumeMute,
  output half_db_t volumeGainHalfDb
);

  reg_byte_t out2_config_one;
  reg_byte_t out2_config_two;
  reg_byte_t dac2a_volume;
  reg_byte_t next_out2_config_one;
  reg_byte_t next_out2_config_two;
  reg_byte_t next_dac2a_volume;

  logic hitOne;
  logic hitTwo;
  logic hitVolume;
  logic hitAny;

  logic [7:0] next_regReadData;
  logic next_regReadValid;
  logic next_regAddrError;
  logic next_reservedWriteSeen;

  // address decode
  always_comb begin
    hitOne = (regAddr == `ADDR_OUT2_CONFIG_ONE);
    hitTwo = (regAddr == `ADDR_OUT2_CONFIG_TWO);
    hitVolume = (regAddr == `ADDR_DAC2A_VOLUME);
    hitAny = hitOne | hitTwo | hitVolume;
  end

  // register writes; reserved bits never stored
  always_comb begin
    next_out2_config_one = out2_config_one;
    next_out2_config_two = out2_config_two;
    next_dac2a_volume = dac2a_volume;
    if (regWrite && hitOne) begin
      next_out2_config_one = regWriteData & `MASK_OUT2_CONFIG_ONE;
    end
    if (regWrite && hitTwo) begin
      next_out2_config_two = regWriteData & `MASK_OUT2_CONFIG_TWO;
    end
    if (regWrite && hitVolume) begin
      next_dac2a_volume = regWriteData & `MASK_DAC2A_VOLUME;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out2_config_one <= `RESET_OUT2_CONFIG_ONE;
      out2_config_two <= `RESET_OUT2_CONFIG_TWO;
      dac2a_volume <= `RESET_DAC2A_VOLUME;
    end else begin
      out2_config_one <= next_out2_config_one;
      out2_config_two <= next_out2_config_two;
      dac2a_volume <= next_dac2a_volume;
    end
  end

  // read port answers one cycle after the strobe, old value on collision
  always_comb begin
    next_regReadData = 8'h00;
    next_regReadValid = regRead;
    next_regAddrError = 1'b0;
    next_reservedWriteSeen = reservedWriteSeen;
    if (regRead) begin
      unique case (1'b1)
        hitOne: next_regReadData = out2_config_one;
        hitTwo: next_regReadData = out2_config_two;
        hitVolume: next_regReadData = dac2a_volume;
        default: next_regReadData = 8'h00;
      endcase
    end
    if ((regRead || regWrite) && !hitAny) begin
      next_regAddrError = 1'b1;
    end
    // sticky report of software writing ones into reserved bits
    if (regWrite && hitOne &&
        ((regWriteData & `BITS_RESERVED_ONE) != 8'h00)) begin
      next_reservedWriteSeen = 1'b1;
    end
    if (regWrite && hitTwo &&
        ((regWriteData & `BITS_RESERVED_TWO) != 8'h00)) begin
      next_reservedWriteSeen = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regReadData <= 8'h00;
      regReadValid <= 1'b0;
      regAddrError <= 1'b0;
      reservedWriteSeen <= 1'b0;
    end else begin
      regReadData <= next_regReadData;
      regReadValid <= next_regReadValid;
      regAddrError <= next_regAddrError;
      reservedWriteSeen <= next_reservedWriteSeen;
    end
  end

  // raw fields straight from the register flops
  assign pos_leg_drive_type =
    out2_config_one[`LEG_DRIVE_MSB:`LEG_DRIVE_LSB];
  assign pos_leg_level_code =
    out2_config_one[`LEG_LEVEL_MSB:`LEG_LEVEL_LSB];
  assign neg_leg_drive_type =
    out2_config_two[`LEG_DRIVE_MSB:`LEG_DRIVE_LSB];
  assign neg_leg_level_code =
    out2_config_two[`LEG_LEVEL_MSB:`LEG_LEVEL_LSB];
  assign dac2_bandwidth_sel = out2_config_one[`BIT_BANDWIDTH_SEL];
  assign dac2_full_scale_sel = out2_config_two[`BIT_FULL_SCALE_SEL];
  assign dac2_common_mode_tolerance =
    out2_config_two[`BIT_COMMON_MODE_TOL];
  assign dac2a_volume_code = dac2a_volume;

  // per-leg decode: leg 0 positive, leg 1 negative
  reg_byte_t legReg [2];
  logic [3:0] legOneHot [2];
  logic [4:0] legAtten [2];
  logic legInvalid [2];

  assign legReg[0] = out2_config_one;
  assign legReg[1] = out2_config_two;

  genvar leg;
  generate
    for (leg = 0; leg < 2; leg++) begin : gen_leg
      drive_type_t driveType;
      logic [2:0] levelCode;
      logic [3:0] next_oneHot;
      logic [4:0] next_atten;
      logic next_invalid;

      always_comb begin
        driveType = drive_type_t'(
          legReg[leg][`LEG_DRIVE_MSB:`LEG_DRIVE_LSB]);
        levelCode = legReg[leg][`LEG_LEVEL_MSB:`LEG_LEVEL_LSB];
        next_oneHot = 4'h0;
        unique case (driveType)
          DRIVE_LINE_OUT: next_oneHot = 4'h1;
          DRIVE_HEADPHONE: next_oneHot = 4'h2;
          DRIVE_LOAD_4OHM: next_oneHot = 4'h4;
          DRIVE_RECEIVER_DEBUG: next_oneHot = 4'h8;
        endcase
        // forbidden codes 0-3 give no attenuation and raise a flag
        next_invalid = (levelCode < `LEVEL_CODE_FIRST_LEGAL);
        unique case (levelCode)
          3'h4: next_atten = `LEVEL_ATTEN_CODE4;
          3'h5: next_atten = `LEVEL_ATTEN_CODE5;
          3'h6: next_atten = `LEVEL_ATTEN_CODE6;
          3'h7: next_atten = `LEVEL_ATTEN_CODE7;
          default: next_atten = 5'h00;
        endcase
      end

      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          legOneHot[leg] <= 4'h1;
          legAtten[leg] <= `LEVEL_ATTEN_CODE4;
          legInvalid[leg] <= 1'b0;
        end else begin
          legOneHot[leg] <= next_oneHot;
          legAtten[leg] <= next_atten;
          legInvalid[leg] <= next_invalid;
        end
      end
    end
  endgenerate

  assign posLegDriveOneHot = legOneHot[0];
  assign negLegDriveOneHot = legOneHot[1];
  assign posLegAttenDb = legAtten[0];
  assign negLegAttenDb = legAtten[1];
  assign posLegLevelInvalid = legInvalid[0];
  assign negLegLevelInvalid = legInvalid[1];

  dac2a_volume_decode volumeDecode (
    .clock(clock),
    .rst(rst),
    .dac2a_volume_code(dac2a_volume),
    .volumeMute(volumeMute),
    .volumeGainHalfDb(volumeGainHalfDb)
  );

endmodule

// ---- shared/dac2_cfg_defines.svh ----
`ifndef DAC2_CFG_DEFINES_SVH
`define DAC2_CFG_DEFINES_SVH

// register offsets
`define ADDR_OUT2_CONFIG_ONE 8'h6C
`define ADDR_OUT2_CONFIG_TWO 8'h6D
`define ADDR_DAC2A_VOLUME 8'h6E

// reset values
`define RESET_OUT2_CONFIG_ONE 8'h20
`define RESET_OUT2_CONFIG_TWO 8'h20
`define RESET_DAC2A_VOLUME 8'hC9

// writable bits; reserved bits are cleared by these masks
`define MASK_OUT2_CONFIG_ONE 8'hF9
`define MASK_OUT2_CONFIG_TWO 8'hFB
`define MASK_DAC2A_VOLUME 8'hFF

// field positions; drive and level fields shared by both leg registers, the rest per register
`define LEG_DRIVE_MSB 7
`define LEG_DRIVE_LSB 6
`define LEG_LEVEL_MSB 5
`define LEG_LEVEL_LSB 3
`define BIT_BANDWIDTH_SEL 0
`define BIT_FULL_SCALE_SEL 1
`define BIT_COMMON_MODE_TOL 0
`define BITS_RESERVED_ONE 8'h06
`define BITS_RESERVED_TWO 8'h04

// level codes and attenuation in dB
`define LEVEL_CODE_FIRST_LEGAL 3'h4
`define LEVEL_ATTEN_CODE4 5'h08
`define LEVEL_ATTEN_CODE5 5'h0E
`define LEVEL_ATTEN_CODE6 5'h14
`define LEVEL_ATTEN_CODE7 5'h1A

// volume: code 0 mutes, code 201 is 0 dB, 0.5 dB per step
`define VOLUME_MUTE_CODE 8'h00
`define VOLUME_UNITY_CODE 9'h0C9

`endif

// ---- shared/dac2_cfg_pkg.sv ----
package dac2_cfg_pkg;

  // output leg drive type, in register encoding order
  typedef enum logic [1:0] {
    DRIVE_LINE_OUT,
    DRIVE_HEADPHONE,
    DRIVE_LOAD_4OHM,
    DRIVE_RECEIVER_DEBUG
  } drive_type_t;

  typedef logic [7:0] reg_byte_t;
  typedef logic signed [8:0] half_db_t;

endpackage

// ---- hdl/dac2a_volume_decode.sv ----
`timescale 1ns/1ns
`include "dac2_cfg_defines.svh"

module dac2a_volume_decode
  import dac2_cfg_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] dac2a_volume_code,
  output logic volumeMute,
  output half_db_t volumeGainHalfDb
);

  logic next_volumeMute;
  half_db_t next_volumeGainHalfDb;

  // gain in 0.5 dB units relative to unity code
  always_comb begin
    next_volumeMute = (dac2a_volume_code == `VOLUME_MUTE_CODE);
    if (next_volumeMute) begin
      next_volumeGainHalfDb = '0;
    end else begin
      next_volumeGainHalfDb =
        half_db_t'({1'b0, dac2a_volume_code} - `VOLUME_UNITY_CODE);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      volumeMute <= 1'b0;
      volumeGainHalfDb <= '0;
    end else begin
      volumeMute <= next_volumeMute;
      volumeGainHalfDb <= next_volumeGainHalfDb;
    end
  end

endmodule

// ---- tb/dac2_output_config_regs_monitor.sv ----
`timescale 1ns/1ns
module dac2_output_config_regs_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic [7:0] regReadData,
  input wire logic regReadValid,
  input wire logic regAddrError,
  input wire logic [1:0] pos_leg_drive_type,
  input wire logic [2:0] pos_leg_level_code,
  input wire logic dac2_bandwidth_sel,
  input wire logic [7:0] dac2a_volume_code,
  input wire logic [3:0] posLegDriveOneHot,
  input wire logic [4:0] posLegAttenDb,
  input wire logic posLegLevelInvalid,
  input wire logic volumeMute
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_read_valid_pulse: assert property (regRead |=> regReadValid ##1
    !regReadValid || $past(regRead)) else $error("read valid timing");
  a_reserved_one_zero: assert property (regRead && regAddr == 8'h6C
    |=> (regReadData & 8'h06) == 8'h00) else $error("reserved bits set");
  a_write_pos_fields: assert property (regWrite && regAddr == 8'h6C
    |=> pos_leg_drive_type == $past(regWriteData[7:6])
    && pos_leg_level_code == $past(regWriteData[5:3])
    && dac2_bandwidth_sel == $past(regWriteData[0]))
    else $error("positive leg fields");
  a_write_volume_code: assert property (regWrite && regAddr == 8'h6E
    |=> dac2a_volume_code == $past(regWriteData)) else $error("volume");
  a_level_five_atten: assert property (pos_leg_level_code == 3'h5
    |=> posLegAttenDb == 5'h0E) else $error("atten code 5");
  a_level_code_invalid: assert property ((pos_leg_level_code < 3'h4)
    |=> posLegLevelInvalid) else $error("invalid flag");
  a_volume_zero_mute: assert property (dac2a_volume_code == 8'h00
    |=> volumeMute) else $error("mute");
  a_debug_drive_hot: assert property (pos_leg_drive_type == 2'h3
    |=> posLegDriveOneHot == 4'h8) else $error("drive one-hot");
  a_unmapped_read_zero: assert property (regRead && regAddr > 8'h6E
    |=> regAddrError && regReadData == 8'h00) else $error("unmapped read");
  c_write_one: cover property (regWrite && regAddr == 8'h6C);
  c_read_two: cover property (regRead && regAddr == 8'h6D);
  c_mute: cover property (volumeMute);
endmodule
bind dac2_output_config_regs dac2_output_config_regs_monitor u_mon (
  .clock(clock),
  .rst(rst),
  .regWrite(regWrite),
  .regRead(regRead),
  .regAddr(regAddr),
  .regWriteData(regWriteData),
  .regReadData(regReadData),
  .regReadValid(regReadValid),
  .regAddrError(regAddrError),
  .pos_leg_drive_type(pos_leg_drive_type),
  .pos_leg_level_code(pos_leg_level_code),
  .dac2_bandwidth_sel(dac2_bandwidth_sel),
  .dac2a_volume_code(dac2a_volume_code),
  .posLegDriveOneHot(posLegDriveOneHot),
  .posLegAttenDb(posLegAttenDb),
  .posLegLevelInvalid(posLegLevelInvalid),
  .volumeMute(volumeMute)
);

// ---- tb/dac2_output_config_regs_test.sv ----
`timescale 1ns/1ns
module dac2_output_config_regs_test;
  import dac2_cfg_pkg::*;
  logic clock, rst, regWrite, regRead, regReadValid, regAddrError;
  logic reservedWriteSeen, dac2_bandwidth_sel, dac2_full_scale_sel;
  logic dac2_common_mode_tolerance, posLegLevelInvalid, negLegLevelInvalid;
  logic volumeMute;
  logic [7:0] regAddr, regWriteData, regReadData, dac2a_volume_code, p, m;
  logic [1:0] pos_leg_drive_type, neg_leg_drive_type;
  logic [2:0] pos_leg_level_code, neg_leg_level_code;
  logic [3:0] posLegDriveOneHot, negLegDriveOneHot;
  logic [4:0] posLegAttenDb, negLegAttenDb;
  half_db_t volumeGainHalfDb;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [4:0] att[4] = '{5'h08, 5'h0E, 5'h14, 5'h1A};
  logic [7:0] vc[4] = '{8'h00, 8'h01, 8'hC9, 8'hFF};
  logic [8:0] vg[4] = '{9'h000, 9'h138, 9'h000, 9'h036};
  dac2_output_config_regs u_dut (.*);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk("readValid", 9'h001, 9'(regReadValid));
    chk("readData", 9'(e), 9'(regReadData));
  endtask
  task end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWriteData = 8'h00;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(8'h6C, 8'h20);
    rd(8'h6D, 8'h20);
    rd(8'h6E, 8'hC9);
    chk("addrError", 9'h000, 9'(regAddrError));
    chk("sticky", 9'h000, 9'(reservedWriteSeen));
    chk("gain", 9'h000, 9'(volumeGainHalfDb));
    wr(8'h6C, 8'hFF);
    rd(8'h6C, 8'hF9);
    chk("sticky", 9'h001, 9'(reservedWriteSeen));
    wr(8'h6D, 8'hFF);
    rd(8'h6D, 8'hFB);
    for (int i = 0; i < 4; i++) begin
      p = {i[1:0], 3'(i + 4), 2'b00, i[0]};
      m = {2'(3 - i), 3'(7 - i), 1'b0, i[1:0]};
      wr(8'h6C, p);
      wr(8'h6D, m);
      rd(8'h6C, p);
      rd(8'h6D, m);
      chk("posDrive", 9'(i), 9'(pos_leg_drive_type));
      chk("posLvl", 9'(i + 4), 9'(pos_leg_level_code));
      chk("negDrv", 9'(3 - i), 9'(neg_leg_drive_type));
      chk("negLvl", 9'(7 - i), 9'(neg_leg_level_code));
      chk("negInv", 9'h000, 9'(negLegLevelInvalid));
      chk("posHot", 9'(1 << i), 9'(posLegDriveOneHot));
      chk("negHot", 9'(8 >> i), 9'(negLegDriveOneHot));
      chk("posAtt", 9'(att[i]), 9'(posLegAttenDb));
      chk("negAtt", 9'(att[3 - i]), 9'(negLegAttenDb));
      chk("posInv", 9'h000, 9'(posLegLevelInvalid));
      chk("band", 9'(i % 2), 9'(dac2_bandwidth_sel));
      chk("scale", 9'(i / 2), 9'(dac2_full_scale_sel));
      chk("tol", 9'(i % 2), 9'(dac2_common_mode_tolerance));
    end
    wr(8'h6C, 8'h18);
    wr(8'h6D, 8'h10);
    rd(8'h6D, 8'h10);
    chk("posInv", 9'h001, 9'(posLegLevelInvalid));
    chk("negInv", 9'h001, 9'(negLegLevelInvalid));
    chk("negAtt", 9'h000, 9'(negLegAttenDb));
    for (int k = 0; k < 4; k++) begin
      wr(8'h6E, vc[k]);
      rd(8'h6E, vc[k]);
      chk("gain", vg[k], 9'(volumeGainHalfDb));
      chk("mute", 9'(k == 0), 9'(volumeMute));
      chk("volCode", 9'(vc[k]), 9'(dac2a_volume_code));
    end
    // second reset in mid-run must restore every register
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(8'h6C, 8'h20);
    rd(8'h6D, 8'h20);
    rd(8'h6E, 8'hC9);
    chk("sticky", 9'h000, 9'(reservedWriteSeen));
    chk("posInv", 9'h000, 9'(posLegLevelInvalid));
    rd(8'h70, 8'h00);
    chk("addrError", 9'h001, 9'(regAddrError));
    end_of_test();
  end
endmodule
